// ===== shared/aof_map.svh
// Purpose: offsets, reset values and timing counts of the output formatter
// Assumes: 32-bit register bus, one aligned word per register
// Notes:   field layouts live as packed structs in aof_pkg
`ifndef AOF_MAP_SVH
`define AOF_MAP_SVH

// System clock and nominal sample period, in ns
`define AOF_CLK_NS 10
`define AOF_SMP_NS 80
// Cycles per sample slot, per half slot, per 45 degree step
`define AOF_SLOT (`AOF_SMP_NS / `AOF_CLK_NS)
`define AOF_HALF (`AOF_SLOT / 2)
`define AOF_STEP (`AOF_SLOT / 8)

// Register byte offsets
`define AOF_AW 8
`define AOF_OFF_RST 8'h00
`define AOF_OFF_PHS 8'h04
`define AOF_OFF_MODE 8'h08
`define AOF_OFF_FMT 8'h0C
`define AOF_OFF_STAT 8'h10

// Soft reset bit in the reset register
`define AOF_RST_BIT 7
// Reset value of every register
`define AOF_REG_RST 8'h00

// Bus responses
`define AOF_RESP_OK 2'h0
`define AOF_RESP_ERR 2'h2

`endif

// ===== shared/aof_pkg.sv
// Purpose: types of the output formatter
// Assumes: aof_map.svh holds the numbers
// Notes:   struct fields are listed from msb down
package aof_pkg;

    // Output mode codes
    typedef enum logic [1:0] {AOF_FULL, AOF_DDR_SE, AOF_DDR_DIFF, AOF_MODE_RSV} aof_mode_t;

    // Differential driver current codes, zero is the default 3.5mA
    typedef enum logic [2:0] {AOF_I3P50, AOF_I4P00, AOF_I4P50, AOF_I3P00,
                              AOF_I2P50, AOF_I2P10, AOF_I1P75, AOF_I_RSV} aof_drv_t;

    // Output mode register layout
    typedef struct packed {
        logic      term;
        aof_drv_t  drive;
        aof_mode_t mode;
    } aof_omode_t;

    // Clock phase register layout
    typedef struct packed {
        logic       stab;
        logic       inv;
        logic [1:0] phase;
    } aof_phs_t;

    // Format register layout
    typedef struct packed {
        logic scr;
        logic twos;
    } aof_fmt_t;

    // Whole configuration applied per sample
    typedef struct packed {
        aof_omode_t om;
        aof_phs_t   ph;
        aof_fmt_t   fm;
    } aof_cfg_t;

    // Converter sample with its range flag
    typedef struct packed {
        logic        range;
        logic [15:0] bits;
    } aof_smp_t;

endpackage : aof_pkg

// ===== rtl/aof_formatter.sv
// Purpose: format converter samples and drive them to a receiver
// Assumes: sample_in is stable around the rising sample clock edge
// Notes:   slot timing assumes the nominal sample period
// Operation
// - Three output modes, chosen by register or strap
// - Full rate drives sixteen lines, flag, clock
// - DDR single-ended pairs two bits per lane
// - DDR differential: eight pairs plus flag, clock
// - Driver current selectable, default 3.5mA
// - Termination on doubles driver current
// - Range flag shares sample latency
// - Full rate data changes at clock fall
// - DDR lanes change on both clock edges
// - Clock delayed 0, 45, 90, 135 degrees
// - Separate bit inverts both clock lines
// - Offset binary code after reset
// - Two's complement inverts top bit
// - Scrambling XORs lsb into other bits
// - Strap selects full rate or DDR differential
`timescale 1ns/1ps
`include "aof_map.svh"

module aof_formatter (
    input  wire logic                clk_in,
    input  wire logic                reset_in,
    input  wire logic [`AOF_AW-1:0]  s_axi_awaddr_in,
    input  wire logic                s_axi_awvalid_in,
    output logic                     s_axi_awready_out,
    input  wire logic [31:0]         s_axi_wdata_in,
    input  wire logic [3:0]          s_axi_wstrb_in,
    input  wire logic                s_axi_wvalid_in,
    output logic                     s_axi_wready_out,
    output logic [1:0]               s_axi_bresp_out,
    output logic                     s_axi_bvalid_out,
    input  wire logic                s_axi_bready_in,
    input  wire logic [`AOF_AW-1:0]  s_axi_araddr_in,
    input  wire logic                s_axi_arvalid_in,
    output logic                     s_axi_arready_out,
    output logic [31:0]              s_axi_rdata_out,
    output logic [1:0]               s_axi_rresp_out,
    output logic                     s_axi_rvalid_out,
    input  wire logic                s_axi_rready_in,
    input  wire logic                sample_clk_in,
    input  wire aof_pkg::aof_smp_t   sample_in,
    input  wire logic                cfg_style_select_in,
    input  wire logic                mode_strap_in,
    output logic [15:0]              sample_bits_out,
    output logic [7:0]               paired_bit_lane_p_out,
    output logic [7:0]               paired_bit_lane_n_out,
    output logic                     range_flag_p_out,
    output logic                     range_flag_n_out,
    output logic                     fwd_clk_p_out,
    output logic                     fwd_clk_n_out,
    output logic                     diff_en_out,
    output aof_pkg::aof_drv_t        drive_sel_out,
    output logic                     drive_double_out,
    output logic                     term_en_out
);
    import aof_pkg::*;

    // Slot positions as counter values
    localparam logic [2:0] HALF_C = 3'(`AOF_HALF);
    localparam logic [2:0] LAST_C = 3'(`AOF_SLOT - 1);
    localparam int         HP1    = `AOF_HALF + 1;

    // Offset binary in, two's complement then scrambling
    function automatic logic [15:0] aof_fmt(input logic [15:0] raw, input aof_fmt_t f);
        logic [15:0] w;
        w     = raw;
        w[15] = raw[15] ^ f.twos;
        if (f.scr) begin
            w[15:1] = w[15:1] ^ {15{w[0]}};
        end
        return w;
    endfunction : aof_fmt

    // True for an offset that holds a register
    function automatic logic aof_mapped(input logic [`AOF_AW-1:0] a);
        return a == `AOF_OFF_RST || a == `AOF_OFF_PHS || a == `AOF_OFF_MODE ||
               a == `AOF_OFF_FMT || a == `AOF_OFF_STAT;
    endfunction : aof_mapped

    logic [19:0]        sync1_ff;     // First sync stage of pins
    logic [19:0]        sync2_ff;     // Second sync stage
    logic               sclk_d_ff;    // Sample clock, one cycle late
    logic               smp_edge;     // Rising sample clock edge
    aof_smp_t           raw_s;        // Synced sample
    logic               par_s;        // Parallel configuration style
    logic               strap_s;      // Synced mode strap
    aof_omode_t         om_ff;        // Output mode register
    aof_phs_t           ph_ff;        // Clock phase register
    aof_fmt_t           fm_ff;        // Format register
    aof_cfg_t           nxt_cfg;      // Settings for the next sample
    aof_cfg_t           cfg_ff;       // Settings of the current sample
    logic [15:0]        word_ff;      // Formatted sample
    logic               range_ff;     // Its range flag
    logic [2:0]         cnt_ff;       // Position in the sample slot
    logic [7:0]         even_w;       // Even bits of each lane pair
    logic [7:0]         odd_w;        // Odd bits of each lane pair
    logic               is_ddr;       // Either double rate mode
    logic               is_diff;      // Differential mode
    logic [2:0]         shift;        // Clock delay in cycles
    logic [2:0]         pos;          // Slot position seen by the clock
    logic               diff_ff;      // Differential drivers on
    logic [15:0]        bits_ff;      // Full rate data lines
    logic [7:0]         lane_p_ff;    // Lane true side
    logic [7:0]         lane_n_ff;    // Lane complement side
    logic               rng_p_ff;     // Range flag true side
    logic               rng_n_ff;     // Range flag complement side
    logic               clk_p_ff;     // Forwarded clock true side
    logic               clk_n_ff;     // Forwarded clock complement
    logic [`AOF_AW-1:0] awaddr_ff;    // Held write address
    logic               aw_got_ff;    // Write address held
    logic [7:0]         wdata_ff;     // Held write data, low byte
    logic               wstrb_ff;     // Low byte lane enabled
    logic               w_got_ff;     // Write data held
    logic               awready_ff;   // Address channel ready
    logic               wready_ff;    // Data channel ready
    logic               bvalid_ff;    // Write answer pending
    logic [1:0]         bresp_ff;     // Write answer code
    logic               arready_ff;   // Read address ready
    logic               rvalid_ff;    // Read answer pending
    logic [31:0]        rdata_ff;     // Read answer data
    logic [1:0]         rresp_ff;     // Read answer code
    logic [7:0]         rd_mux;       // Register selected for read
    logic               wr_go;        // Commit a held write

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    // Two flops on every pin from outside the clock domain
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= {sample_clk_in, sample_in, cfg_style_select_in, mode_strap_in};
            sync2_ff <= sync1_ff;
        end
    end

    assign raw_s   = aof_smp_t'(sync2_ff[18:2]);
    assign par_s   = sync2_ff[1];
    assign strap_s = sync2_ff[0];

    // Sample clock edge finder
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            sclk_d_ff <= 1'b0;
        end else begin
            sclk_d_ff <= sync2_ff[19];
        end
    end

    assign smp_edge = sync2_ff[19] & ~sclk_d_ff;

    // Settings for the next sample, strap or registers
    always_comb begin
        nxt_cfg = {om_ff, ph_ff, fm_ff};
        if (par_s) begin
            nxt_cfg         = '0;
            nxt_cfg.om.mode = strap_s ? AOF_DDR_DIFF : AOF_FULL;
        end
        if (nxt_cfg.om.mode == AOF_MODE_RSV) begin
            nxt_cfg.om.mode = AOF_FULL;
        end
        if (nxt_cfg.om.drive == AOF_I_RSV) begin
            nxt_cfg.om.drive = AOF_I3P50;
        end
        if (nxt_cfg.om.mode != AOF_DDR_DIFF) begin
            nxt_cfg.om.term = 1'b0;
        end
    end

    // Latch sample, flag and settings together at the boundary
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            cfg_ff   <= '0;
            word_ff  <= '0;
            range_ff <= 1'b0;
            diff_ff  <= 1'b0;
        end else if (smp_edge) begin
            cfg_ff   <= nxt_cfg;
            word_ff  <= aof_fmt(raw_s.bits, nxt_cfg.fm);
            range_ff <= raw_s.range;
            diff_ff  <= nxt_cfg.om.mode == AOF_DDR_DIFF;
        end
    end

    a_cfg_boundary: assert property (!smp_edge |=> $stable(cfg_ff))
        else $error("settings changed inside a sample");
    a_twos_msb: assert property (smp_edge && !nxt_cfg.fm.scr |=>
        word_ff[15] == ($past(raw_s.bits[15]) ^ cfg_ff.fm.twos))
        else $error("top bit not formatted");
    a_scramble_bits: assert property (smp_edge && nxt_cfg.fm.scr |=>
        word_ff[0] == $past(raw_s.bits[0]) &&
        word_ff[14] == ($past(raw_s.bits[14]) ^ $past(raw_s.bits[0])))
        else $error("scrambling wrong");
    a_strap_mode: assert property (smp_edge && par_s && strap_s |=>
        cfg_ff.om.mode == AOF_DDR_DIFF && cfg_ff.om.drive == AOF_I3P50 && !cfg_ff.om.term)
        else $error("strap mode wrong");

    // Slot counter restarts at every sample edge
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            cnt_ff <= 3'h0;
        end else if (smp_edge || cnt_ff == LAST_C) begin
            cnt_ff <= 3'h0;
        end else begin
            cnt_ff <= cnt_ff + 3'h1;
        end
    end

    // Split the word into lane pairs
    for (genvar k = 0; k < 8; k++) begin : g_lane
        assign even_w[k] = word_ff[2*k];
        assign odd_w[k]  = word_ff[2*k+1];
    end

    assign is_ddr  = cfg_ff.om.mode != AOF_FULL;
    assign is_diff = cfg_ff.om.mode == AOF_DDR_DIFF;

    // Data lines: load at slot start, odd bits at half slot
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            bits_ff   <= '0;
            lane_p_ff <= '0;
            lane_n_ff <= '0;
            rng_p_ff  <= 1'b0;
            rng_n_ff  <= 1'b0;
        end else if (cnt_ff == 3'h0) begin
            rng_p_ff <= range_ff;
            rng_n_ff <= is_diff & ~range_ff;
            if (is_ddr) begin
                bits_ff   <= '0;
                lane_p_ff <= even_w;
                lane_n_ff <= is_diff ? ~even_w : 8'h00;
            end else begin
                bits_ff   <= word_ff;
                lane_p_ff <= '0;
                lane_n_ff <= '0;
            end
        end else if (cnt_ff == HALF_C && is_ddr) begin
            lane_p_ff <= odd_w;
            lane_n_ff <= is_diff ? ~odd_w : 8'h00;
        end
    end

    a_full_data: assert property (cnt_ff == 3'h1 && !is_ddr |->
        sample_bits_out == word_ff && paired_bit_lane_p_out == 8'h00)
        else $error("full rate data wrong");
    a_ddr_even: assert property (cnt_ff == 3'h1 && is_ddr |->
        paired_bit_lane_p_out == even_w && sample_bits_out == 16'h0000)
        else $error("even lane bits wrong");
    a_ddr_odd: assert property (cnt_ff == 3'(HP1) && is_ddr |->
        paired_bit_lane_p_out == odd_w)
        else $error("odd lane bits wrong");
    a_diff_pairs: assert property (cnt_ff == 3'h1 && is_diff |->
        paired_bit_lane_n_out == ~paired_bit_lane_p_out && range_flag_n_out == !range_flag_p_out)
        else $error("pair sides not complementary");
    a_range_latency: assert property (cnt_ff == 3'h1 |-> range_flag_p_out == range_ff)
        else $error("range flag out of step");

    // Shift applies only with the stabilizer on
    assign shift = cfg_ff.ph.stab ? 3'(cfg_ff.ph.phase * `AOF_STEP) : 3'h0;
    assign pos   = cnt_ff - shift;

    // Forwarded clock: low in first half, shifted, maybe inverted
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            clk_p_ff <= 1'b0;
            clk_n_ff <= 1'b1;
        end else begin
            clk_p_ff <= (pos >= HALF_C) ^ cfg_ff.ph.inv;
            clk_n_ff <= (pos < HALF_C) ^ cfg_ff.ph.inv;
        end
    end

    a_clk_fall: assert property (cnt_ff == 3'h1 && shift == 3'h0 && !cfg_ff.ph.inv |->
        !fwd_clk_p_out && fwd_clk_n_out)
        else $error("clock not low at data change");
    a_clk_phase: assert property (cnt_ff == 3'(HP1) && cfg_ff.ph.stab && !cfg_ff.ph.inv |->
        fwd_clk_p_out == (cfg_ff.ph.phase == 2'h0))
        else $error("clock phase wrong");
    a_clk_invert: assert property (cnt_ff == 3'h1 && shift == 3'h0 && cfg_ff.ph.inv |->
        fwd_clk_p_out && !fwd_clk_n_out)
        else $error("clock not inverted");

    c_full: cover property (cnt_ff == 3'h1 && !is_ddr && sample_bits_out != 16'h0000);
    c_diff: cover property (cnt_ff == 3'(HP1) && is_diff);
    c_scr: cover property (smp_edge && nxt_cfg.fm.scr && nxt_cfg.om.mode == AOF_DDR_SE);

    assign sample_bits_out       = bits_ff;
    assign paired_bit_lane_p_out = lane_p_ff;
    assign paired_bit_lane_n_out = lane_n_ff;
    assign range_flag_p_out      = rng_p_ff;
    assign range_flag_n_out      = rng_n_ff;
    assign fwd_clk_p_out         = clk_p_ff;
    assign fwd_clk_n_out         = clk_n_ff;
    assign diff_en_out           = diff_ff;
    assign drive_sel_out         = cfg_ff.om.drive;
    assign drive_double_out      = cfg_ff.om.term;
    assign term_en_out           = cfg_ff.om.term;

    // Write channels: hold address and data until both arrive
    assign wr_go = aw_got_ff & w_got_ff & ~bvalid_ff;

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            aw_got_ff  <= 1'b0;
            awready_ff <= 1'b1;
            awaddr_ff  <= '0;
        end else if (s_axi_awvalid_in && awready_ff) begin
            aw_got_ff  <= 1'b1;
            awready_ff <= 1'b0;
            awaddr_ff  <= s_axi_awaddr_in;
        end else if (wr_go) begin
            aw_got_ff  <= 1'b0;
            awready_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            w_got_ff  <= 1'b0;
            wready_ff <= 1'b1;
            wdata_ff  <= '0;
            wstrb_ff  <= 1'b0;
        end else if (s_axi_wvalid_in && wready_ff) begin
            w_got_ff  <= 1'b1;
            wready_ff <= 1'b0;
            wdata_ff  <= s_axi_wdata_in[7:0];
            wstrb_ff  <= s_axi_wstrb_in[0];
        end else if (wr_go) begin
            w_got_ff  <= 1'b0;
            wready_ff <= 1'b1;
        end
    end

    // Write answer after commit, held until taken
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= `AOF_RESP_OK;
        end else if (wr_go) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= aof_mapped(awaddr_ff) ? `AOF_RESP_OK : `AOF_RESP_ERR;
        end else if (s_axi_bready_in) begin
            bvalid_ff <= 1'b0;
        end
    end

    // Register writes; soft reset clears all settings
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            om_ff <= aof_omode_t'(`AOF_REG_RST);
            ph_ff <= aof_phs_t'(`AOF_REG_RST);
            fm_ff <= aof_fmt_t'(`AOF_REG_RST);
        end else if (wr_go && wstrb_ff) begin
            case (awaddr_ff)
                `AOF_OFF_RST: begin
                    if (wdata_ff[`AOF_RST_BIT]) begin
                        om_ff <= aof_omode_t'(`AOF_REG_RST);
                        ph_ff <= aof_phs_t'(`AOF_REG_RST);
                        fm_ff <= aof_fmt_t'(`AOF_REG_RST);
                    end
                end
                `AOF_OFF_PHS:  ph_ff <= aof_phs_t'(wdata_ff[$bits(aof_phs_t)-1:0]);
                `AOF_OFF_MODE: om_ff <= aof_omode_t'(wdata_ff[$bits(aof_omode_t)-1:0]);
                `AOF_OFF_FMT:  fm_ff <= aof_fmt_t'(wdata_ff[$bits(aof_fmt_t)-1:0]);
                default: ;
            endcase
        end
    end

    // Read selection; reset register reads zero
    always_comb begin
        case (s_axi_araddr_in)
            `AOF_OFF_PHS:  rd_mux = 8'({ph_ff});
            `AOF_OFF_MODE: rd_mux = 8'({om_ff});
            `AOF_OFF_FMT:  rd_mux = 8'({fm_ff});
            `AOF_OFF_STAT: rd_mux = {par_s, range_ff, cfg_ff.om};
            default:       rd_mux = 8'h00;
        endcase
    end

    // Read answer one cycle after the address
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= '0;
            rresp_ff   <= `AOF_RESP_OK;
        end else if (s_axi_arvalid_in && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b1;
            rdata_ff   <= {24'h000000, rd_mux};
            rresp_ff   <= aof_mapped(s_axi_araddr_in) ? `AOF_RESP_OK : `AOF_RESP_ERR;
        end else if (rvalid_ff && s_axi_rready_in) begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
        end
    end

    assign s_axi_awready_out = awready_ff;
    assign s_axi_wready_out  = wready_ff;
    assign s_axi_bvalid_out  = bvalid_ff;
    assign s_axi_bresp_out   = bresp_ff;
    assign s_axi_arready_out = arready_ff;
    assign s_axi_rvalid_out  = rvalid_ff;
    assign s_axi_rdata_out   = rdata_ff;
    assign s_axi_rresp_out   = rresp_ff;

endmodule : aof_formatter

// ===== verif/aof_rx_model.sv
// Purpose: receiver model latching the formatter's data lines
// Assumes: clock phase leaves margin at both clock edges in DDR modes
// Notes:   restores scrambled words before handing them on
`timescale 1ns/1ps
module aof_rx_model (
    input  wire logic        clk_p_in,
    input  wire logic [15:0] bits_in,
    input  wire logic [7:0]  lane_in,
    input  wire logic        flag_in,
    input  wire logic        ddr_in,
    input  wire logic        unscr_in,
    output logic [15:0]      word_out,
    output logic             flag_out
);
    logic [7:0]  even_ff;  // Even bits caught at the clock fall
    logic [15:0] raw;      // Word as it arrived on the lines
    // First half of a DDR slot carries the even bits
    always @(negedge clk_p_in) even_ff <= lane_in;
    // Rising edge closes the word in every mode
    always @(posedge clk_p_in) begin
        for (int k = 0; k < 8; k++) begin
            raw[2*k]   = ddr_in ? even_ff[k] : bits_in[2*k];
            raw[2*k+1] = ddr_in ? lane_in[k] : bits_in[2*k+1];
        end
        word_out <= unscr_in ? raw ^ {{15{raw[0]}}, 1'h0} : raw;
        flag_out <= flag_in;
    end
endmodule : aof_rx_model

// ===== verif/test_adc_output_formatter.sv
// Purpose: self-checking bench of the output formatter
// Assumes: sample clock made from clk_in, 80 ns period
// Notes:   DDR cases use a 90 degree clock shift for capture margin
`timescale 1ns/1ps
module test_adc_output_formatter;
    import aof_pkg::*;
    logic        clk_in = 1'h0, reset_in = 1'h1, awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
    logic        scl = 1'h0, style = 1'h0, strap = 1'h0, ddr = 1'h0, unscr = 1'h0;
    logic [7:0]  awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h00000000, rd, rdat;
    logic [1:0]  rr, br, rresp;
    logic        awr, wr, bv, arr, rv, fp, fn, ckp, ckn, den, dbl, trm, rxf;
    logic [15:0] bits, rxw, exp_w, exp_p;
    logic [7:0]  lp, ln;
    logic [2:0]  sc = 3'h0;
    aof_drv_t    drv;
    aof_smp_t    smp_in = '0, nxt_smp = '0;
    int          err_total = 0, total_checks = 0;

    aof_formatter dut (.clk_in(clk_in), .reset_in(reset_in), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
        .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv),
        .s_axi_wready_out(wr), .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(bry),
        .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rdat),
        .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv), .s_axi_rready_in(rry), .sample_clk_in(scl),
        .sample_in(smp_in), .cfg_style_select_in(style), .mode_strap_in(strap), .sample_bits_out(bits),
        .paired_bit_lane_p_out(lp), .paired_bit_lane_n_out(ln), .range_flag_p_out(fp), .range_flag_n_out(fn),
        .fwd_clk_p_out(ckp), .fwd_clk_n_out(ckn), .diff_en_out(den), .drive_sel_out(drv),
        .drive_double_out(dbl), .term_en_out(trm));
    aof_rx_model rx (.clk_p_in(ckp), .bits_in(bits), .lane_in(lp), .flag_in(fp), .ddr_in(ddr),
        .unscr_in(unscr), .word_out(rxw), .flag_out(rxf));

    // System clock
    initial begin
        forever #5 clk_in = ~clk_in;
    end
    // Sample clock and sample pins; samples change at the sample clock fall
    always @(posedge clk_in) begin
        sc <= sc + 3'h1;
        if (sc == 3'h3) scl <= 1'h1;
        if (sc == 3'h7) begin
            scl    <= 1'h0;
            smp_in <= nxt_smp;
        end
    end

    task give_verdict;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : give_verdict

    task chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    // A missing answer counts as a mismatch and ends the run
    task tmo(input logic ok);
        if (ok !== 1'h1) begin
            err_total++;
            $display("wrong value at %0t: bus answer missing", $time);
            give_verdict();
        end
    endtask : tmo

    // Write: an edge passes first, so no strobe is set twice in one step
    task axi_wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        awa <= a;
        wd  <= d;
        awv <= 1'h1;
        wv  <= 1'h1;
        bry <= 1'h1;
        do begin
            @(posedge clk_in);
            if (awr) awv <= 1'h0;
            if (wr) wv <= 1'h0;
            n++;
        end while (bv !== 1'h1 && n < 50);
        bry <= 1'h0;
        tmo(bv);
        chk({30'h0, br}, 32'h0);
    endtask : axi_wr

    // Read: data and response taken at the edge that shows rvalid
    task axi_rd(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge clk_in);
        ara <= a;
        arv <= 1'h1;
        rry <= 1'h1;
        do begin
            @(posedge clk_in);
            if (arr) arv <= 1'h0;
            rd = rdat;
            rr = rresp;
            n++;
        end while (rv !== 1'h1 && n < 50);
        rry <= 1'h0;
        tmo(rv);
    endtask : axi_rd

    // Program phase, mode and format, send one sample, check both ends
    task run(input logic [7:0] ph, input logic [7:0] m, input logic [7:0] f, input logic [16:0] s);
        axi_wr(8'h04, {24'h0, ph});
        axi_wr(8'h08, {24'h0, m});
        axi_wr(8'h0C, {24'h0, f});
        nxt_smp <= aof_smp_t'(s);
        exp_w = s[15:0] ^ {f[0], 15'h0};
        exp_p = f[1] ? exp_w ^ {{15{exp_w[0]}}, 1'h0} : exp_w;
        ddr   <= (m[1:0] == 2'h1 || m[1:0] == 2'h2);
        unscr <= f[1];
        repeat (48) @(posedge clk_in);
        chk({16'h0, rxw}, {16'h0, exp_w});
        chk({30'h0, fp, rxf}, {30'h0, s[16], s[16]});
        chk({31'h0, fn}, {31'h0, m[1:0] == 2'h2 && !s[16]});
        chk({31'h0, ckn}, {31'h0, ~ckp});
        chk({16'h0, bits}, ddr ? 32'h0 : {16'h0, exp_p});
    endtask : run

    initial begin
        repeat (6) @(posedge clk_in);
        reset_in <= 1'h0;
        axi_rd(8'h08);
        chk(rd, 32'h0);
        axi_rd(8'h20);
        chk({30'h0, rr}, 32'h2);
        run(8'h00, 8'h00, 8'h00, 17'h1FFFF);
        run(8'h00, 8'h03, 8'h01, 17'h00000);
        run(8'h00, 8'h00, 8'h03, 17'h0ABCD);
        run(8'h0D, 8'h00, 8'h00, 17'h18001);
        run(8'h0A, 8'h01, 8'h02, 17'h15A5B);
        run(8'h0A, 8'h2A, 8'h01, 17'h07F00);
        chk({31'h0, den}, 32'h1);
        chk({24'h0, ln}, {24'h0, ~lp});
        chk({29'h0, drv}, {29'h0, AOF_I4P50});
        chk({30'h0, dbl, trm}, 32'h3);
        axi_rd(8'h08);
        chk(rd, 32'h2A);
        style <= 1'h1;
        strap <= 1'h1;
        repeat (48) @(posedge clk_in);
        chk({28'h0, den, drv}, {28'h0, 1'h1, AOF_I3P50});
        chk({31'h0, trm}, 32'h0);
        strap <= 1'h0;
        repeat (48) @(posedge clk_in);
        chk({16'h0, bits}, 32'h7F00);
        style <= 1'h0;
        axi_wr(8'h04, 32'h05);
        repeat (24) @(posedge clk_in);
        chk({31'h0, ckn}, {31'h0, ~ckp});
        axi_wr(8'h00, 32'h80);
        repeat (24) @(posedge clk_in);
        axi_rd(8'h08);
        chk(rd, 32'h0);
        give_verdict();
    end
endmodule : test_adc_output_formatter
